// ==== pmr_regbank.sv ====
// Serial target and control register bank of the power controller
`timescale 1ns/1ps
module pmr_regbank #(
   parameter logic [3:0]            DEF_ON    = 4'hf,
   parameter logic                  DEF_SEQ   = 1'b0,
   parameter pmr_pkg::pmr_codes_type DEF_CODES = {8'h85, 8'h85, 8'h45, 8'h08}
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output      logic                    sda_out,
   output      logic                    sda_drive_n,
   input  wire logic                    en_pin,
   input  wire logic                    undervoltage_in,
   input  wire logic                    overtemp_in,
   input  wire logic [3:0]              valid_in,
   output      logic                    fault_irq_n,
   output      pmr_pkg::pmr_enable_type supply_ctrl,
   output      pmr_pkg::pmr_codes_type  volt_codes,
   output      logic [11:0]             buck_target_mv
);

   // ---------------------------------------------------------------
   // Pin synchronisation and edges
   // ---------------------------------------------------------------
   logic [8:0] sync_q;
   logic       scl_s, sda_s, en_s, uv_s, ot_s;
   logic [3:0] valid_s;
   logic       scl_d, sda_d, en_d, fault_d;
   logic       scl_rise, scl_fall, start_c, stop_c;
   logic       fault_lvl, fault_rise, en_rise, en_fall;

   // Bus lines idle high, so they come out of reset high
   pmr_sync #(
      .WIDTH   (9),
      .RST_VAL (9'h003)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({valid_in, overtemp_in, undervoltage_in, en_pin, sda_in, scl_in}),
      .q   (sync_q)
   );

   assign scl_s   = sync_q[0];
   assign sda_s   = sync_q[1];
   assign en_s    = sync_q[2];
   assign uv_s    = sync_q[3];
   assign ot_s    = sync_q[4];
   assign valid_s = sync_q[8:5];

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_d   <= 1'b1;
         sda_d   <= 1'b1;
         en_d    <= 1'b0;
         fault_d <= 1'b0;
      end else begin
         scl_d   <= scl_s;
         sda_d   <= sda_s;
         en_d    <= en_s;
         fault_d <= fault_lvl;
      end
   end

   assign scl_rise   = scl_s & ~scl_d;
   assign scl_fall   = ~scl_s & scl_d;
   assign start_c    = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c     = scl_s & scl_d & ~sda_d & sda_s;
   assign fault_lvl  = uv_s | ot_s;
   assign fault_rise = fault_lvl & ~fault_d;
   // Pin tied high before reset release still gives a startup
   assign en_rise    = en_s & ~en_d;
   assign en_fall    = ~en_s & en_d;

   // ---------------------------------------------------------------
   // Serial target engine
   // ---------------------------------------------------------------
   pmr_pkg::pmr_i2c_state_type state;
   logic [3:0] cnt;
   logic       ack_phase;
   logic [7:0] shift, tx, rd_data;
   logic [2:0] ptr;
   logic       byte_done, ack_end, addr_hit, wr_now, wr_status;

   assign byte_done = scl_fall & ~ack_phase & (cnt == pmr_pkg::BYTE_BITS);
   assign ack_end   = scl_fall & ack_phase;
   assign addr_hit  = (shift[7:1] == pmr_pkg::DEV_ADDR);
   // Commit lands on the fall that opens the ack slot
   assign wr_now    = byte_done & (state == pmr_pkg::st_wdata);
   assign wr_status = wr_now & (ptr == pmr_pkg::REG_STATUS);

   always_ff @(posedge clk) begin
      if (rst) begin
         state       <= pmr_pkg::st_idle;
         cnt         <= 4'h0;
         ack_phase   <= 1'b0;
         shift       <= 8'h00;
         tx          <= 8'h00;
         ptr         <= 3'h0;
         sda_drive_n <= 1'b1;
         sda_out     <= 1'b0;
      end else if (start_c) begin
         state       <= pmr_pkg::st_addr;
         cnt         <= 4'h0;
         ack_phase   <= 1'b0;
         sda_drive_n <= 1'b1;
      end else if (stop_c) begin
         state       <= pmr_pkg::st_idle;
         ack_phase   <= 1'b0;
         sda_drive_n <= 1'b1;
      end else begin
         if (scl_rise && !ack_phase && state != pmr_pkg::st_idle) begin
            if (state != pmr_pkg::st_rdata) begin
               shift <= {shift[6:0], sda_s};
            end
            cnt <= cnt + 4'h1;
         end
         // Host nack ends a read burst
         if (scl_rise && ack_phase && state == pmr_pkg::st_rdata && sda_s) begin
            state <= pmr_pkg::st_idle;
         end
         if (byte_done) begin
            ack_phase <= 1'b1;
            case (state)
               pmr_pkg::st_addr: begin
                  if (addr_hit) begin
                     sda_drive_n <= 1'b0;
                  end else begin
                     state     <= pmr_pkg::st_idle;
                     ack_phase <= 1'b0;
                  end
               end
               pmr_pkg::st_reg: begin
                  ptr         <= shift[2:0];
                  sda_drive_n <= 1'b0;
               end
               pmr_pkg::st_wdata: sda_drive_n <= 1'b0;
               pmr_pkg::st_rdata: begin
                  sda_drive_n <= 1'b1;
                  ptr         <= ptr + 3'h1;
               end
               default: ack_phase <= 1'b0;
            endcase
         end else if (ack_end) begin
            ack_phase   <= 1'b0;
            cnt         <= 4'h0;
            sda_drive_n <= 1'b1;
            case (state)
               pmr_pkg::st_addr: begin
                  if (shift[0]) begin
                     state       <= pmr_pkg::st_rdata;
                     tx          <= rd_data;
                     sda_drive_n <= rd_data[7];
                  end else begin
                     state <= pmr_pkg::st_reg;
                  end
               end
               pmr_pkg::st_reg:   state <= pmr_pkg::st_wdata;
               pmr_pkg::st_wdata: ptr <= ptr + 3'h1;
               pmr_pkg::st_rdata: begin
                  tx          <= rd_data;
                  sda_drive_n <= rd_data[7];
               end
               default: cnt <= 4'h0;
            endcase
         end else if (scl_fall && state == pmr_pkg::st_rdata && cnt != 4'h0) begin
            tx          <= {tx[6:0], 1'b0};
            sda_drive_n <= tx[6];
         end
      end
   end

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   pmr_pkg::pmr_enable_type en_reg;
   pmr_pkg::pmr_codes_type  codes;
   logic                    int_en, uv_flag, ot_flag, wr_code;

   assign wr_code = wr_now && ptr >= pmr_pkg::REG_BUCK && ptr <= pmr_pkg::REG_LIN3;

   // Fault outranks the pin and the bus in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         en_reg.restart_after_fault <= pmr_pkg::RESTART_POR;
         en_reg.sequence_disable    <= pmr_pkg::SEQ_POR;
         en_reg.supply_on           <= pmr_pkg::ON_POR;
      end else if (fault_rise) begin
         en_reg.sequence_disable <= 1'b0;
         en_reg.supply_on        <= en_reg.restart_after_fault ? DEF_ON : 4'h0;
      end else if (en_rise) begin
         en_reg.sequence_disable <= DEF_SEQ;
         en_reg.supply_on        <= DEF_ON;
      end else if (en_fall) begin
         en_reg.supply_on <= 4'h0;
      end else if (wr_now && ptr == pmr_pkg::REG_ENABLE) begin
         en_reg <= shift[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         int_en <= pmr_pkg::INTEN_POR;
      end else if (wr_status) begin
         int_en <= shift[pmr_pkg::BIT_INTEN];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         codes <= DEF_CODES;
      end else if (fault_rise) begin
         codes <= DEF_CODES;
      end else if (wr_code) begin
         codes[pmr_pkg::pmr_code_index(ptr)] <= shift;
      end
   end

   pmr_sticky_flag u_uv_flag (
      .clk (clk),
      .rst (rst),
      .set (uv_s),
      .clr (wr_status & shift[pmr_pkg::BIT_UV]),
      .q   (uv_flag)
   );

   pmr_sticky_flag u_ot_flag (
      .clk (clk),
      .rst (rst),
      .set (ot_s),
      .clr (wr_status & shift[pmr_pkg::BIT_OT]),
      .q   (ot_flag)
   );

   // Reads have no side effects, so the mux is pure
   always_comb begin
      case (ptr)
         pmr_pkg::REG_ENABLE: rd_data = {2'b00, en_reg};
         pmr_pkg::REG_STATUS: rd_data = {1'b0, int_en, uv_flag, ot_flag, valid_s};
         pmr_pkg::REG_BUCK,
         pmr_pkg::REG_LIN1,
         pmr_pkg::REG_LIN2,
         pmr_pkg::REG_LIN3:   rd_data = codes[pmr_pkg::pmr_code_index(ptr)];
         default:             rd_data = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign volt_codes = codes;

   // Supplies stay dark while the fault lasts; restart follows from en_reg
   always_ff @(posedge clk) begin
      if (rst) begin
         supply_ctrl    <= '0;
         fault_irq_n    <= 1'b1;
         buck_target_mv <= pmr_pkg::BUCK_BASE_MV;
      end else begin
         supply_ctrl           <= en_reg;
         supply_ctrl.supply_on <= fault_lvl ? 4'h0 : en_reg.supply_on;
         fault_irq_n           <= ~(int_en & (uv_flag | ot_flag));
         buck_target_mv        <= pmr_pkg::pmr_buck_mv(codes[0]);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_fault_edge;
      fault_lvl && !fault_d;
   endsequence

   sequence s_addr_byte;
      byte_done && state == pmr_pkg::st_addr;
   endsequence

   AST_FAULT_DARK: assert property (fault_lvl |=> supply_ctrl.supply_on == 4'h0)
      else $error("supply on during fault");
   AST_FAULT_DEFAULTS: assert property (s_fault_edge |=>
      codes == DEF_CODES && !en_reg.sequence_disable
      && en_reg.restart_after_fault == $past(en_reg.restart_after_fault))
      else $error("fault did not load defaults");
   AST_IRQ_ON: assert property (int_en && (uv_flag || ot_flag) |=> !fault_irq_n)
      else $error("interrupt not asserted");
   AST_IRQ_MASK: assert property (!int_en |=> fault_irq_n)
      else $error("interrupt asserted while disabled");
   AST_EN_START: assert property (en_rise && !fault_rise |=>
      en_reg.supply_on == DEF_ON && en_reg.sequence_disable == DEF_SEQ)
      else $error("startup defaults not loaded");
   AST_ACK_CODE: assert property (wr_now && ptr == pmr_pkg::REG_BUCK && !fault_rise |=>
      volt_codes[0] == $past(shift))
      else $error("voltage code not applied at ack");
   AST_ADDR_ACK: assert property ((s_addr_byte and addr_hit) |=> !sda_drive_n)
      else $error("own address not acknowledged");
   AST_ADDR_NACK: assert property ((s_addr_byte and !addr_hit) |=> sda_drive_n [*2])
      else $error("foreign address acknowledged");
   AST_REG_PTR: assert property (byte_done && state == pmr_pkg::st_reg |=>
      ptr == $past(shift[2:0]))
      else $error("register pointer not from low bits");
   AST_UNUSED_ZERO: assert property (ptr > pmr_pkg::REG_LIN3 |-> rd_data == 8'h00)
      else $error("unused address reads nonzero");
   AST_STATUS_TOP: assert property (ptr == pmr_pkg::REG_STATUS |-> !rd_data[7])
      else $error("reserved status bit set");
endmodule

// ==== pmr_pkg.sv ====
// Constants and types shared by the power controller register bank
package pmr_pkg;

   // ---------------------------------------------------------------
   // Bus addressing
   // ---------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR   = 7'h5a;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [2:0] REG_ENABLE = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_BUCK   = 3'h2;
   localparam logic [2:0] REG_LIN1   = 3'h3;
   localparam logic [2:0] REG_LIN2   = 3'h4;
   localparam logic [2:0] REG_LIN3   = 3'h5;

   // ---------------------------------------------------------------
   // Field positions and power-on values
   // ---------------------------------------------------------------
   localparam int         BIT_INTEN   = 6;
   localparam int         BIT_UV      = 5;
   localparam int         BIT_OT      = 4;
   localparam logic       RESTART_POR = 1'b1;
   localparam logic       SEQ_POR     = 1'b0;
   localparam logic [3:0] ON_POR      = 4'h0;
   localparam logic       INTEN_POR   = 1'b0;

   // ---------------------------------------------------------------
   // Buck code scale in millivolts
   // ---------------------------------------------------------------
   localparam logic [11:0] BUCK_BASE_MV   = 12'h320;
   localparam logic [11:0] BUCK_MID_MV    = 12'h4b0;
   localparam logic [11:0] BUCK_MAX_MV    = 12'h708;
   localparam logic [11:0] BUCK_FINE_MV   = 12'h019;
   localparam logic [11:0] BUCK_COARSE_MV = 12'h032;
   localparam logic [7:0]  BUCK_COARSE_CD = 8'h10;
   localparam logic [7:0]  BUCK_MAX_CD    = 8'h1c;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       restart_after_fault;
      logic       sequence_disable;
      logic [3:0] supply_on;
   } pmr_enable_type;

   typedef logic [3:0][7:0] pmr_codes_type;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_reg,
      st_wdata,
      st_rdata
   } pmr_i2c_state_type;

   // Buck code to target millivolts; codes past the top clamp
   function automatic logic [11:0] pmr_buck_mv(input logic [7:0] code);
      logic [7:0] off;
      off = code - BUCK_COARSE_CD;
      if (code < BUCK_COARSE_CD) begin
         pmr_buck_mv = BUCK_BASE_MV + 12'(code[3:0]) * BUCK_FINE_MV;
      end else if (code <= BUCK_MAX_CD) begin
         pmr_buck_mv = BUCK_MID_MV + 12'(off[3:0]) * BUCK_COARSE_MV;
      end else begin
         pmr_buck_mv = BUCK_MAX_MV;
      end
   endfunction

   function automatic logic [1:0] pmr_code_index(input logic [2:0] ptr);
      logic [2:0] d;
      d = ptr - REG_BUCK;
      pmr_code_index = d[1:0];
   endfunction

endpackage

// ==== pmr_sync.sv ====
// Two-flop synchroniser for pins entering the clk domain
`timescale 1ns/1ps
module pmr_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ==== pmr_sticky_flag.sv ====
// Sticky fault flag with write-one-to-clear
`timescale 1ns/1ps
module pmr_sticky_flag (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   output      logic q
);
   // ---------------------------------------------------------------
   // Flag
   // ---------------------------------------------------------------
   // Set beats clear so a live fault re-arms at once
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_FLAG_REARM: assert property (set |=> q)
      else $error("flag not set by live fault");
   AST_FLAG_ECHO: assert property (clr && !set |=> !q)
      else $error("flag not cleared by echo");
   AST_FLAG_HOLD: assert property (q && !clr |=> q)
      else $error("flag dropped without echo");
endmodule

// ==== pmr_host_model.sv ====
// Behavioural bus host reaching the register bank over its serial pins
`timescale 1ns/1ps
module pmr_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output      logic scl,
   output      logic sda_rel
);
   // ----------------------------------------
   // Pin timing: quarter bit of two clocks
   // ----------------------------------------
   // Clock stands still and data is released between frames
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   task automatic q();
      repeat (2) @(posedge clk);
   endtask

   // Start, or repeated start when the clock is low
   task automatic start();
      sda_rel <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_rel <= 1'b0;
      q();
      scl <= 1'b0;
      q();
   endtask

   task automatic stop();
      sda_rel <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_rel <= 1'b1;
      q();
   endtask

   // Sampled mid-high, away from the edges the target reacts to
   task automatic xfer(input logic b, output logic r);
      sda_rel <= b;
      q();
      scl <= 1'b1;
      q();
      @(negedge clk);
      r = sda_line;
      q();
      scl <= 1'b0;
      q();
   endtask

   task automatic tx_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(b[i], r);
      end
      xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic write_reg(input logic [7:0] dev, input logic [7:0] ra,
                            input logic [7:0] wd, output logic ok);
      logic a0, a1, a2;
      a1 = 1'b0;
      a2 = 1'b0;
      start();
      tx_byte(dev, a0);
      if (a0) begin
         tx_byte(ra, a1);
         tx_byte(wd, a2);
      end
      stop();
      ok = a0 & a1 & a2;
   endtask

   // Last byte is refused so the target lets go of the line
   task automatic read_regs(input logic [7:0] ra, input int n, output logic [15:0] d);
      logic a, r;
      d = '0;
      start();
      tx_byte(8'hb4, a);
      tx_byte(ra, a);
      start();
      tx_byte(8'hb5, a);
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, r);
            d = {d[14:0], r};
         end
         xfer(k == n - 1, r);
      end
      stop();
   endtask
endmodule

// ==== tb_pmr_regbank.sv ====
// Self-checking bench for the power controller register bank
`timescale 1ns/1ps
module tb_pmr_regbank;
   // ----------------------------------------
   // Signals and table of ordinary cases
   // ----------------------------------------
   localparam pmr_pkg::pmr_codes_type DEFC = {8'h85, 8'h85, 8'h45, 8'h08};
   typedef struct packed {
      logic [7:0]  ra;
      logic [7:0]  wd;
      logic [7:0]  rd;
      logic [11:0] mv;
   } pmr_row_type;
   logic                    clk, rst, scl, sda_rel, sda_drive_n, en_pin;
   logic                    uv, ot, fault_irq_n, ok, sda_o;
   logic [3:0]              valid;
   logic [11:0]             buck_mv;
   logic [15:0]             d;
   pmr_pkg::pmr_enable_type ctrl;
   pmr_pkg::pmr_codes_type  codes;
   wire logic               sda_line;
   int                      errors, compares;
   pmr_row_type             rows [10] = '{
      '{8'h02, 8'h0f, 8'h0f, 12'h497},
      '{8'h0a, 8'h10, 8'h10, 12'h4b0},
      '{8'hfa, 8'h1c, 8'h1c, 12'h708},
      '{8'h03, 8'h45, 8'h45, 12'h000},
      '{8'h04, 8'hba, 8'hba, 12'h000},
      '{8'h05, 8'he8, 8'he8, 12'h000},
      '{8'h00, 8'hff, 8'h3f, 12'h000},
      '{8'h01, 8'hff, 8'h40, 12'h000},
      '{8'h06, 8'hff, 8'h00, 12'h000},
      '{8'h07, 8'h55, 8'h00, 12'h000}};

   // Open drain: the target only ever pulls to its output value
   assign sda_line = sda_rel & (sda_drive_n | sda_o);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   pmr_regbank #(
      .DEF_ON    (4'hf),
      .DEF_SEQ   (1'b0),
      .DEF_CODES (DEFC)
   ) dut_u (
      .clk             (clk),
      .rst             (rst),
      .scl_in          (scl),
      .sda_in          (sda_line),
      .sda_out         (sda_o),
      .sda_drive_n     (sda_drive_n),
      .en_pin          (en_pin),
      .undervoltage_in (uv),
      .overtemp_in     (ot),
      .valid_in        (valid),
      .fault_irq_n     (fault_irq_n),
      .supply_ctrl     (ctrl),
      .volt_codes      (codes),
      .buck_target_mv  (buck_mv)
   );

   pmr_host_model host_u (
      .clk      (clk),
      .sda_line (sda_line),
      .scl      (scl),
      .sda_rel  (sda_rel)
   );

   // ----------------------------------------
   // Checking and bus helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] ra, input logic [15:0] exp, input int n);
      host_u.read_regs(ra, n, d);
      chk(d, exp);
   endtask

   task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
      host_u.write_reg(8'hb4, ra, wd, ok);
      chk(ok, 1'b1);
   endtask

   task automatic settle();
      repeat (10) @(posedge clk);
   endtask

   task automatic end_sim();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Whole run needs about 1.3 ms; generous margin
   initial begin
      #5000000;
      errors++;
      end_sim();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      en_pin = 1'b0;
      uv = 1'b0;
      ot = 1'b0;
      valid = 4'h0;
      errors = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk({ctrl, fault_irq_n, sda_drive_n, sda_o}, {6'h20, 3'b110});
      for (int i = 0; i < 6; i++) begin
         rdchk(8'(i), (i == 0) ? 16'h20 : (i == 1) ? 16'h00 : 16'(DEFC[i-2]), 1);
      end
      $display("end of reset test");
      foreach (rows[i]) begin
         wr(rows[i].ra, rows[i].wd);
         if (rows[i].ra[2:0] inside {[3'h2:3'h5]}) begin
            chk(codes[rows[i].ra[2:0] - 3'h2], rows[i].wd);
         end
         rdchk(rows[i].ra, 16'(rows[i].rd), 1);
         if (rows[i].mv != 12'h000) begin
            chk(buck_mv, rows[i].mv);
         end
      end
      $display("end of register table test");
      wr(8'h00, 8'h30);
      en_pin <= 1'b1;
      settle();
      rdchk(8'h00, 16'h2f, 1);
      en_pin <= 1'b0;
      settle();
      $display("end of enable pin test");
      wr(8'h00, 8'h3a);
      valid <= 4'h5;
      uv <= 1'b1;
      settle();
      chk(codes, DEFC);
      chk({fault_irq_n, ctrl}, {1'b0, 6'h20});
      rdchk(8'h00, 16'h2f, 1);
      rdchk(8'h01, 16'h65, 1);
      wr(8'h01, 8'h60);
      rdchk(8'h01, 16'h65, 1);
      uv <= 1'b0;
      settle();
      wr(8'h01, 8'h40);
      rdchk(8'h01, 16'h65, 1);
      chk(fault_irq_n, 1'b0);
      wr(8'h01, 8'h60);
      rdchk(8'h01, 16'h45, 1);
      chk({fault_irq_n, ctrl}, {1'b1, 6'h2f});
      wr(8'h00, 8'h0f);
      ot <= 1'b1;
      settle();
      ot <= 1'b0;
      settle();
      rdchk(8'h00, 16'h00, 1);
      wr(8'h01, 8'h00);
      rdchk(8'h01, 16'h15, 1);
      chk(fault_irq_n, 1'b1);
      $display("end of fault test");
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdchk(8'h01, 16'h05, 1);
      host_u.write_reg(8'hb6, 8'h02, 8'h77, ok);
      chk(ok, 1'b0);
      host_u.write_reg(8'h34, 8'h02, 8'h77, ok);
      chk(ok, 1'b0);
      rdchk(8'h02, 16'h0845, 2);
      rdchk(8'h05, 16'h8500, 2);
      $display("end of address and word read test");
      end_sim();
   end
endmodule
